/* dv/accumulator_move_and_return_ops_tb_top.sv */
`timescale 1ns/10ps
module accumulator_move_and_return_ops_tb_top
   import amr_pkg::*;
;
   logic mclk_i = 0, rst_i = 1, ld_en = 0, push = 0;
   logic [11:0] word = 12'h000, insn;
   logic [7:0] ld = 8'h00, acc, setup, wdata;
   logic [8:0] paddr = 9'h000, pc, p;
   logic [4:0] faddr;
   logic [1:0] lvl;
   logic we, flush, fwe;
   int n_fail = 0, n_tests = 0, cyc = 0;
   amr_fetch_model u_mem (.flush_i(flush), .word_i(word), .insn_o(insn));
   amr_core u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .insn_i(insn),
      .acc_load_i(ld), .acc_load_en_i(ld_en), .push_i(push),
      .push_addr_i(paddr), .acc_o(acc), .setup_o(setup), .file_we_o(we),
      .file_addr_o(faddr), .file_wdata_o(wdata), .pc_o(pc),
      .flush_o(flush), .flags_we_o(fwe), .stack_level_o(lvl));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   // ****************************************
   // Checking and stepping
   // ****************************************
   task automatic end_of_test();
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Inputs change at the falling edge, results read just after rising
   task automatic step(input logic [11:0] w, input logic le,
         input logic [7:0] l, input logic pu, input logic [8:0] a);
      @(negedge mclk_i);
      word = w;
      ld_en = le;
      ld = l;
      push = pu;
      paddr = a;
      @(posedge mclk_i);
      #1;
   endtask : step
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_setup();
      step(12'hfff, 1'b1, 8'ha5, 1'b0, 9'h000);
      step(OP_SETUP_LOAD, 1'b0, 8'h00, 1'b0, 9'h000);
      chk(setup, 12'h0a5);
      chk(fwe, 12'h000);
      chk(we, 12'h000);
   endtask : t_setup
   task automatic t_store();
      for (int i = 0; i < 32; i += 31) begin
         step(12'hfff, 1'b1, 8'h3c ^ 8'(i), 1'b0, 9'h000);
         step(12'h020 | 12'(i), 1'b0, 8'h00, 1'b0, 9'h000);
         chk(we, 12'h001);
         chk(faddr, 12'(i));
         chk(wdata, 12'h03c ^ 12'(i));
         p = pc;
         step(OP_NOP, 1'b0, 8'h00, 1'b0, 9'h000);
         chk(we, 12'h000);
         chk(pc, 12'(p) + 12'h001);
         chk(acc, 12'h03c ^ 12'(i));
      end
   endtask : t_store
   task automatic t_return();
      step(OP_NOP, 1'b0, 8'h00, 1'b1, 9'h123);
      step(OP_NOP, 1'b0, 8'h00, 1'b1, 9'h0aa);
      chk(lvl, 12'h003);
      step(12'h8ff, 1'b0, 8'h00, 1'b0, 9'h000);
      chk(acc, 12'h0ff);
      chk(pc, 12'h0aa);
      chk(lvl, 12'h001);
      chk(flush, 12'h001);
      step(12'h002, 1'b1, 8'h11, 1'b0, 9'h000);
      chk(acc, 12'h0ff);
      chk(pc, 12'h0ab);
      chk(flush, 12'h000);
      step(12'h800, 1'b0, 8'h00, 1'b0, 9'h000);
      chk(acc, 12'h000);
      chk(pc, 12'h123);
      chk(fwe, 12'h000);
   endtask : t_return
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 500) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_i = 0;
      chk(setup, 12'h0ff);
      chk(pc, 12'h000);
      t_setup();
      t_store();
      t_return();
      end_of_test();
   end
endmodule : accumulator_move_and_return_ops_tb_top

/* dv/amr_fetch_model.sv */
`timescale 1ns/10ps
module amr_fetch_model
   import amr_pkg::*;
(
   input wire logic flush_i,
   input wire logic [INSN_W-1:0] word_i,
   output logic [INSN_W-1:0] insn_o
);
   // Discarded fetch carries a stale, inverted word, never a clean one
   always_comb begin
      insn_o = flush_i ? ~word_i : word_i;
   end
endmodule : amr_fetch_model

/* pkg/amr_pkg.sv */
package amr_pkg;
   // ****************************************
   // Instruction word layout
   // ****************************************
   localparam int INSN_W = 12;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int PC_W = 9;
   localparam int STACK_DEPTH = 2;
   localparam logic [INSN_W-1:0] OP_NOP = 12'h000;
   localparam logic [INSN_W-1:0] OP_SETUP_LOAD = 12'h002;
   localparam logic [6:0] OP_STORE_TOP = 7'h01;
   localparam int STORE_TOP_LSB = 5;
   localparam logic [3:0] OP_RETURN_TOP = 4'h8;
   localparam int RETURN_TOP_LSB = 8;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] SETUP_RESET = 8'hff;
   localparam logic [PC_W-1:0] PC_RESET = 9'h000;

   typedef enum logic [4:0] {
      AMR_NOP = 5'b00001,
      AMR_STORE = 5'b00010,
      AMR_SETUP = 5'b00100,
      AMR_RETURN = 5'b01000,
      AMR_OTHER = 5'b10000
   } amr_op_type;

   typedef enum logic [1:0] {
      AMR_EXEC = 2'b01,
      AMR_FLUSH = 2'b10
   } amr_state_type;
endpackage : amr_pkg

/* verilog/amr_core.sv */
`timescale 1ns/10ps
module amr_core
   import amr_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [INSN_W-1:0] insn_i,
   input wire logic [DATA_W-1:0] acc_load_i,
   input wire logic acc_load_en_i,
   input wire logic push_i,
   input wire logic [PC_W-1:0] push_addr_i,
   output logic [DATA_W-1:0] acc_o,
   output logic [DATA_W-1:0] setup_o,
   output logic file_we_o,
   output logic [FADDR_W-1:0] file_addr_o,
   output logic [DATA_W-1:0] file_wdata_o,
   output logic [PC_W-1:0] pc_o,
   output logic flush_o,
   output logic flags_we_o,
   output logic [STACK_DEPTH-1:0] stack_level_o
);
   // ****************************************
   // Decode
   // ****************************************
   amr_op_type op;
   amr_state_type state, next_state;
   logic [DATA_W-1:0] next_acc, next_setup, next_file_wdata;
   logic next_file_we;
   logic [FADDR_W-1:0] next_file_addr;
   logic [PC_W-1:0] next_pc;
   logic [PC_W-1:0] stack [STACK_DEPTH];
   logic [PC_W-1:0] next_stack [STACK_DEPTH];
   logic [STACK_DEPTH-1:0] next_level;
   logic exec;
   logic next_flush;

   amr_decode u_dec (
      .insn_i(insn_i),
      .op_o(op)
   );

   // Flush cycle ignores the word fetched before the jump
   assign exec = (state == AMR_EXEC);

   // ****************************************
   // Helpers
   // ****************************************
   // Counter wraps at its width; page bits belong to the wider core
   function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
      return pc + PC_W'(1);
   endfunction : pc_step

   // ****************************************
   // Next-state
   // ****************************************
   always_comb begin
      next_state = AMR_EXEC;
      next_flush = 1'b0;
      next_acc = acc_o;
      next_setup = setup_o;
      next_file_we = 1'b0;
      next_file_addr = file_addr_o;
      next_file_wdata = file_wdata_o;
      next_pc = pc_step(pc_o);
      next_stack = stack;
      next_level = stack_level_o;
      if (exec) begin
         unique case (op)
            AMR_NOP: begin
            end
            AMR_STORE: begin
               next_file_we = 1'b1;
               next_file_addr = insn_i[FADDR_W-1:0];
               next_file_wdata = acc_o;
            end
            AMR_SETUP: begin
               next_setup = acc_o;
            end
            AMR_RETURN: begin
               // Literal rides in the low byte under the opcode nibble
               next_acc = insn_i[DATA_W-1:0];
               next_pc = stack[0];
               next_stack[0] = stack[1];
               next_level = stack_level_o >> 1;
               next_state = AMR_FLUSH;
               next_flush = 1'b1;
            end
            AMR_OTHER: begin
               if (acc_load_en_i) begin
                  next_acc = acc_load_i;
               end
            end
         endcase
      end
      // Call push from the wider core; depth-two stack drops oldest
      if (push_i && !(exec && op == AMR_RETURN)) begin
         next_stack[1] = stack[0];
         next_stack[0] = push_addr_i;
         next_level = {stack_level_o[0], 1'b1};
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= AMR_EXEC;
         acc_o <= ACC_RESET;
         setup_o <= SETUP_RESET;
         file_we_o <= 1'b0;
         file_addr_o <= '0;
         file_wdata_o <= '0;
         pc_o <= PC_RESET;
         stack <= '{default: PC_RESET};
         stack_level_o <= '0;
         flush_o <= 1'b0;
      end else begin
         state <= next_state;
         acc_o <= next_acc;
         setup_o <= next_setup;
         file_we_o <= next_file_we;
         file_addr_o <= next_file_addr;
         file_wdata_o <= next_file_wdata;
         pc_o <= next_pc;
         stack <= next_stack;
         stack_level_o <= next_level;
         flush_o <= next_flush;
      end
   end

   // None of these four instructions touches status flags
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_we_o <= 1'b0;
      end else begin
         flags_we_o <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence seq_return;
      exec && op == AMR_RETURN;
   endsequence

   sequence seq_flushed;
      flush_o && !exec ##1 exec;
   endsequence

   // The discarded cycle must leave the accumulator and file alone; the counter still steps
   sequence seq_discard;
      !exec;
   endsequence

   chk_setup_copy: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      exec && op == AMR_SETUP |=> setup_o == $past(acc_o))
      else $error("setup register not loaded from accumulator");
   chk_setup_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !(exec && op == AMR_SETUP) |=> $stable(setup_o))
      else $error("setup register changed without setup-load");
   chk_return_acc: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> acc_o == $past(insn_i[DATA_W-1:0]))
      else $error("accumulator not loaded with literal");
   chk_return_pc: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> pc_o == $past(stack[0]))
      else $error("program counter not loaded from stack top");
   chk_return_pop: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> stack[0] == $past(stack[1]))
      else $error("return stack not popped");
   chk_return_two: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> seq_flushed)
      else $error("literal-return did not take two cycles");
   chk_store_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      exec && op == AMR_STORE |=> file_we_o &&
      file_addr_o == $past(insn_i[FADDR_W-1:0]) &&
      file_wdata_o == $past(acc_o))
      else $error("store did not write file register");
   chk_nop_quiet: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      exec && op == AMR_NOP && !push_i |=> !file_we_o && $stable(acc_o)
      && pc_o == $past(pc_o) + 9'h001)
      else $error("no-operation changed state");
   chk_flags_quiet: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !flags_we_o)
      else $error("status flags written");

   // ****************************************
   // Side-effect and discard checks
   // ****************************************
   chk_setup_keep: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      exec && op == AMR_SETUP |=> $stable(acc_o) && !file_we_o)
      else $error("setup-load disturbed accumulator or file");
   chk_return_quiet: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> !file_we_o && $stable(setup_o))
      else $error("literal-return wrote file or setup register");
   chk_return_level: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_return |=> !stack_level_o[STACK_DEPTH-1])
      else $error("return stack occupancy not reduced");
   // A call in the same cycle as a return is dropped, so exclude it
   chk_push_top: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      push_i && !(exec && op == AMR_RETURN)
      |=> stack[0] == $past(push_addr_i))
      else $error("pushed return address not on stack top");
   chk_discard_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_discard |=> $stable(acc_o) && !file_we_o)
      else $error("discarded word changed state");
   chk_discard_pc: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_discard |=> pc_o == $past(pc_o) + 9'h001)
      else $error("program counter not stepped in discard cycle");
   chk_discard_once: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      seq_discard |=> exec)
      else $error("discard lasted more than one cycle");
   // File strobe may only follow a decoded store
   chk_store_pulse: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      file_we_o |-> $past(exec && op == AMR_STORE))
      else $error("file write without store");
   chk_store_keep: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      exec && op == AMR_STORE |=> $stable(acc_o) && $stable(setup_o)
      && pc_o == $past(pc_o) + 9'h001)
      else $error("store disturbed accumulator, setup or counter");
endmodule : amr_core

/* verilog/amr_decode.sv */
`timescale 1ns/10ps
module amr_decode
   import amr_pkg::*;
(
   input wire logic [INSN_W-1:0] insn_i,
   output amr_op_type op_o
);
   always_comb begin
      if (insn_i == OP_NOP) begin
         op_o = AMR_NOP;
      end else if (insn_i == OP_SETUP_LOAD) begin
         op_o = AMR_SETUP;
      end else if (insn_i[INSN_W-1:STORE_TOP_LSB] == OP_STORE_TOP) begin
         op_o = AMR_STORE;
      end else if (insn_i[INSN_W-1:RETURN_TOP_LSB] == OP_RETURN_TOP) begin
         op_o = AMR_RETURN;
      end else begin
         op_o = AMR_OTHER;
      end
   end
endmodule : amr_decode
